// file: logic/ext_bus_pkg.sv
// Package of constants and types for the external memory bus port.
package ext_bus_pkg;

  // ==========================================================================
  // Machine cycle and reset timing
  // ==========================================================================
  localparam int unsigned CLOCKS_PER_MACHINE_CYCLE = 4;  // Oscillator clocks per cycle.
  localparam int unsigned RESET_HOLD_MACHINE_CYCLES = 2; // Least reset hold, in cycles.
  localparam int unsigned RESET_HOLD_CLOCKS =
    CLOCKS_PER_MACHINE_CYCLE * RESET_HOLD_MACHINE_CYCLES;

  // ==========================================================================
  // Stretch range of external data moves
  // ==========================================================================
  localparam logic [3:0] STRETCH_MIN_CYCLES = 4'h2;  // Shortest data move.
  localparam logic [3:0] STRETCH_MAX_CYCLES = 4'h9;  // Longest data move.
  localparam logic [3:0] STRETCH_RESET      = 4'h2;  // Stretch after reset.

  // ==========================================================================
  // Phase positions inside one machine cycle
  // ==========================================================================
  localparam logic [1:0] PHASE_LATCH   = 2'h0;  // Latch strobe high, address out.
  localparam logic [1:0] PHASE_RELEASE = 2'h1;  // Latch strobe low, address held.
  localparam logic [1:0] PHASE_LAST    = 2'h3;  // Last phase of a machine cycle.

  // ==========================================================================
  // Access kinds
  // ==========================================================================
  localparam logic [1:0] KIND_FETCH      = 2'h0;  // Instruction fetch.
  localparam logic [1:0] KIND_TABLE_READ = 2'h1;  // Program table read.
  localparam logic [1:0] KIND_DATA_READ  = 2'h2;  // External data move, read.
  localparam logic [1:0] KIND_DATA_WRITE = 2'h3;  // External data move, write.

  // On-chip SRAM window; only used when the enable bit is set.
  localparam logic [15:0] ONCHIP_SRAM_TOP = 16'h03FF;

endpackage : ext_bus_pkg

// file: logic/external_memory_bus_port.sv
// External memory bus port: address/data multiplexing and bus strobes.
`timescale 1ns/1ps

// Summary of operation
// - All bus activity runs in four-clock machine cycles.
// - Program strobe on fetches and table reads.
// - Latch strobe captures the low address byte.
// - Low port carries address first, then data.
// - High port carries upper address every external access.
// - Write and read strobes for data moves.
// - Wait input extends external accesses.
// - Wait pin never driven while wait enabled.
// - Data moves stretch from two to nine cycles.
// - On-chip SRAM disabled after reset.
module external_memory_bus_port
  import ext_bus_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Core request side, same clock domain.
  input  wire logic        accessRequest,     // Level: start an access when idle.
  input  wire logic [1:0]  accessKind,        // Kind of access, see package.
  input  wire logic [15:0] accessAddress,     // Full 16-bit address.
  input  wire logic [7:0]  writeData,         // Byte for a data write.
  input  wire logic [3:0]  stretchCycles,     // Data move length, two to nine.
  input  wire logic        waitEnable,        // Wait-state pin use enabled.
  input  wire logic        onchipSramEnable,  // Set/clear of the on-chip SRAM enable.
  input  wire logic        onchipSramLoad,    // Pulse: load the enable bit.
  // Core answer side.
  output logic             accessDone,        // Pulse: access finished.
  output logic [7:0]       readData,          // Byte captured from the bus.
  output logic             onchipSelect,      // Pulse: access served on chip.
  output logic             onchip_sram_enable_bit, // Current enable bit.
  // Pins.
  input  wire logic        external_access_select, // Strap: high for internal code.
  output logic             internalCodeSelect,     // Registered strap level.
  input  wire logic [7:0]  lowPortIn,         // Low multiplexed port, input.
  output logic [7:0]       lowPortOut,        // Low multiplexed port, output.
  output logic             lowPortOe,         // Low port driven while high.
  output logic [7:0]       highAddress,       // Upper address byte.
  output logic             addressLatchStrobe,// High one clock as the low address goes out.
  output logic             program_fetch_strobe_n, // Program fetch strobe.
  output logic             writeStrobe_n,     // Data write strobe (P3.6 role).
  output logic             readStrobe_n,      // Data read strobe (P3.7 role).
  input  wire logic        waitPinIn,         // Wait pin input, high asks a wait.
  output logic             waitPinOe          // Wait pin drive enable.
);

  // ==========================================================================
  // Types and state
  // ==========================================================================
  typedef enum logic [2:0] {
    IDLE   = 3'b001,  // No access in progress.
    ACCESS = 3'b010,  // Strobe phases of the access.
    FINISH = 3'b100   // Answer handed back to the core.
  } bus_state_e;

  typedef struct packed {
    bus_state_e  fsm;
    logic [1:0]  kind;
    logic [3:0]  cyclesLeft;
    logic        firstCycle;
    logic [7:0]  dataOut;
    logic [7:0]  readData;
    logic        accessDone;
    logic        onchipSelect;
    logic        sramEnable;
    logic        strapSync1;
    logic        strapSync2;
    logic        waitSync1;
    logic        waitSync2;
    logic [7:0]  lowPortOut;
    logic        lowPortOe;
    logic [7:0]  highAddress;
    logic        latchStrobe;
    logic        fetchStrobe_n;
    logic        writeStrobe_n;
    logic        readStrobe_n;
  } bus_state_s;

  bus_state_s  state;       // Registered state.
  bus_state_s  next_state;  // Next value.
  logic [1:0]  phase;       // Phase inside the machine cycle.
  logic        cycleEnd;    // Pulse on the last phase.

  // Clamp a requested stretch into the legal range of data moves.
  function automatic logic [3:0] clampStretch(input logic [3:0] req);
    if (req < STRETCH_MIN_CYCLES) begin
      return STRETCH_MIN_CYCLES;
    end else if (req > STRETCH_MAX_CYCLES) begin
      return STRETCH_MAX_CYCLES;
    end
    return req;
  endfunction

  // Data kinds use the read or write strobe; program kinds use the fetch strobe.
  function automatic logic isDataKind(input logic [1:0] k);
    return (k == KIND_DATA_READ) || (k == KIND_DATA_WRITE);
  endfunction

  // ==========================================================================
  // Machine cycle divider
  // ==========================================================================
  phase_divider u_phase_divider (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .phase    (phase),
    .cycleEnd (cycleEnd)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Accesses start only at a machine cycle boundary, so every strobe sits in
  // the same phase positions whatever the core timing is.
  always_comb begin
    next_state              = state;
    next_state.accessDone   = 1'b0;
    next_state.onchipSelect = 1'b0;
    // The strap and wait pins pass two flops before any logic looks at them.
    next_state.strapSync1   = external_access_select;
    next_state.strapSync2   = state.strapSync1;
    next_state.waitSync1    = waitPinIn;
    next_state.waitSync2    = state.waitSync1;
    if (onchipSramLoad) begin
      next_state.sramEnable = onchipSramEnable;
    end

    unique case (state.fsm)
      IDLE: begin
        next_state.lowPortOe     = 1'b0;
        next_state.latchStrobe   = 1'b0;
        next_state.fetchStrobe_n = 1'b1;
        next_state.writeStrobe_n = 1'b1;
        next_state.readStrobe_n  = 1'b1;
        if (accessRequest && cycleEnd) begin
          if (isDataKind(accessKind) && state.sramEnable &&
              (accessAddress <= ONCHIP_SRAM_TOP)) begin
            // Served on chip; the external bus stays quiet.
            next_state.onchipSelect = 1'b1;
            next_state.accessDone   = 1'b1;
          end else begin
            next_state.fsm         = ACCESS;
            next_state.kind        = accessKind;
            next_state.firstCycle  = 1'b1;
            next_state.dataOut     = writeData;
            // Program accesses take one machine cycle, data moves stretch.
            next_state.cyclesLeft  = isDataKind(accessKind) ?
                                     clampStretch(stretchCycles) : 4'h1;
            next_state.highAddress = accessAddress[15:8];
            next_state.lowPortOut  = accessAddress[7:0];
            next_state.lowPortOe   = 1'b1;
            next_state.latchStrobe = 1'b1;
          end
        end
      end
      ACCESS: begin
        if (state.firstCycle && phase == PHASE_LATCH) begin
          // Latch strobe falls while the address is still held stable.
          next_state.latchStrobe = 1'b0;
        end else if (state.firstCycle && phase == PHASE_RELEASE) begin
          next_state.firstCycle = 1'b0;
          if (state.kind == KIND_DATA_WRITE) begin
            next_state.lowPortOut    = state.dataOut;
            next_state.writeStrobe_n = 1'b0;
          end else begin
            // Address released in the same clock that the read or fetch strobe falls.
            next_state.lowPortOe = 1'b0;
            if (state.kind == KIND_DATA_READ) begin
              next_state.readStrobe_n = 1'b0;
            end else begin
              next_state.fetchStrobe_n = 1'b0;
            end
          end
        end
        if (cycleEnd) begin
          if (waitEnable && state.waitSync2) begin
            // A slow device holds the access for another machine cycle.
            next_state.cyclesLeft = state.cyclesLeft;
          end else if (state.cyclesLeft == 4'h1) begin
            next_state.fsm           = FINISH;
            next_state.readData      = lowPortIn;
            next_state.fetchStrobe_n = 1'b1;
            next_state.writeStrobe_n = 1'b1;
            next_state.readStrobe_n  = 1'b1;
          end else begin
            next_state.cyclesLeft = state.cyclesLeft - 4'h1;
          end
        end
      end
      FINISH: begin
        // Write data leaves the port once the strobe has risen.
        next_state.lowPortOe  = 1'b0;
        next_state.accessDone = 1'b1;
        next_state.fsm        = IDLE;
      end
      default: begin
        // Codes that are not one-hot are illegal; fall back to idle so that
        // an upset cannot leave the bus state machine stuck.
        next_state.fsm = IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // All strobes rest inactive in reset; the SRAM enable starts cleared.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state               <= '0;
      state.fsm           <= IDLE;
      state.kind          <= KIND_FETCH;
      state.fetchStrobe_n <= 1'b1;
      state.writeStrobe_n <= 1'b1;
      state.readStrobe_n  <= 1'b1;
      state.sramEnable    <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign accessDone             = state.accessDone;
  assign readData               = state.readData;
  assign onchipSelect           = state.onchipSelect;
  assign onchip_sram_enable_bit = state.sramEnable;
  assign internalCodeSelect     = state.strapSync2;
  assign lowPortOut             = state.lowPortOut;
  assign lowPortOe              = state.lowPortOe;
  assign highAddress            = state.highAddress;
  assign addressLatchStrobe     = state.latchStrobe;
  assign program_fetch_strobe_n = state.fetchStrobe_n;
  assign writeStrobe_n          = state.writeStrobe_n;
  assign readStrobe_n           = state.readStrobe_n;
  // The wait pin is an input only here; port use lives elsewhere.
  assign waitPinOe              = 1'b0;

endmodule // external_memory_bus_port

// file: logic/phase_divider.sv
// Divider that marks the four phases of each machine cycle.
`timescale 1ns/1ps
module phase_divider
  import ext_bus_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Phase outputs.
  output logic [1:0] phase,      // Current phase inside a machine cycle.
  output logic       cycleEnd    // One-cycle pulse on the last phase.
);

  // ==========================================================================
  // Phase counter
  // ==========================================================================
  typedef struct packed {
    logic [1:0] phase;
    logic       cycleEnd;
  } div_state_s;

  div_state_s state;       // Registered state.
  div_state_s next_state;  // Next value.

  // The counter wraps naturally at four, one machine cycle.
  always_comb begin
    next_state          = state;
    next_state.phase    = state.phase + 2'h1;
    next_state.cycleEnd = (next_state.phase == PHASE_LAST);
  end

  // Reset lines the counter up at the start of a machine cycle.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign phase    = state.phase;
  assign cycleEnd = state.cycleEnd;

endmodule // phase_divider

// file: sim/external_memory_bus_port_bench.sv
// Self-checking bench of the external memory bus port.
`timescale 1ns/1ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin nFail++; \
  $display("mismatch %0t: got %0h want %0h", $time, g, e); end end
module external_memory_bus_port_bench;
  import ext_bus_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic sys_clk = 1'b0, reset_n = 1'b0, accessRequest = 1'b0, waitEnable = 1'b0;
  logic onchipSramEnable = 1'b0, onchipSramLoad = 1'b0, external_access_select = 1'b1;
  logic [1:0]  accessKind = 2'h0;
  logic [15:0] accessAddress = 16'h0000;
  logic [7:0]  writeData = 8'h00, readData, lowPortIn, lowPortOut, highAddress;
  logic [3:0]  stretchCycles = 4'h2, waitLen = 4'h0;
  logic accessDone, onchipSelect, onchip_sram_enable_bit, internalCodeSelect, lowPortOe;
  logic addressLatchStrobe, program_fetch_strobe_n, writeStrobe_n, readStrobe_n;
  logic waitPinIn, waitPinOe, sawOn;
  int   nFail = 0, checkCount = 0, lat;
  external_memory_bus_port u_external_memory_bus_port (.*);
  memory_partner u_memory_partner (.*);
  initial forever #4 sys_clk = ~sys_clk;
  // One access; lat counts clocks from the take to completion, -1 on a hang.
  task automatic xfer(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    int t0;
    t0 = 0;
    lat = -1;
    sawOn = 1'b0;
    @(negedge sys_clk);
    {accessKind, accessAddress, writeData, accessRequest} = {k, a, d, 1'b1};
    for (int i = 1; i <= 200 && lat < 0; i++) begin
      @(negedge sys_clk);
      if (t0 == 0 && (addressLatchStrobe || onchipSelect)) t0 = i;
      if (t0 != 0) accessRequest = 1'b0;
      if (onchipSelect === 1'b1) sawOn = 1'b1;
      if (accessDone === 1'b1) lat = i - t0;
    end
    accessRequest = 1'b0;
  endtask
  // Idle levels after reset.
  task automatic testReset();
    repeat (3) @(negedge sys_clk);
    `CHK(internalCodeSelect, 1'b1)
    `CHK({program_fetch_strobe_n, readStrobe_n, writeStrobe_n}, 3'h7)
    `CHK({addressLatchStrobe, lowPortOe, waitPinOe}, 3'h0)
    `CHK(onchip_sram_enable_bit, 1'b0)
    // The strap level must pass both flops before it shows, then follow the pin.
    external_access_select = 1'b0;
    @(negedge sys_clk);
    `CHK(internalCodeSelect, 1'b1)
    repeat (2) @(negedge sys_clk);
    `CHK(internalCodeSelect, 1'b0)
    external_access_select = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(internalCodeSelect, 1'b1)
  endtask
  // Back-to-back fetches and table reads take one machine cycle.
  task automatic testProgram();
    logic [15:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 16'h1234 + 16'(i) * 16'h4321;
      xfer(i[0] ? KIND_TABLE_READ : KIND_FETCH, a, 8'h00);
      `CHK(lat, 5)
      `CHK(readData, a[7:0] ^ a[15:8] ^ 8'hA5)
      `CHK(highAddress, a[15:8])
    end
  endtask
  // Writes and read-backs at edge addresses, with stretch limits and clamps.
  task automatic testData();
    logic [3:0]  s [4] = '{4'h2, 4'h9, 4'h0, 4'hF};
    int          n [4] = '{2, 9, 2, 9};
    logic [15:0] a [4] = '{16'h0000, 16'hFFFF, 16'h03FF, 16'h8001};
    for (int i = 0; i < 4; i++) begin
      stretchCycles = s[i];
      xfer(KIND_DATA_WRITE, a[i], 8'h3C + 8'(i));
      `CHK(lat, 4 * n[i] + 1)
      xfer(KIND_DATA_READ, a[i], 8'h00);
      `CHK(lat, 4 * n[i] + 1)
      `CHK(readData, 8'h3C + 8'(i))
      `CHK(highAddress, a[i][15:8])
    end
  endtask
  // A slow memory stretches the read only while waits are enabled.
  task automatic testWait();
    waitLen = 4'h2;
    stretchCycles = 4'h2;
    xfer(KIND_DATA_READ, 16'hFFFF, 8'h00);
    `CHK(lat, 9)
    waitEnable = 1'b1;
    xfer(KIND_DATA_READ, 16'hFFFF, 8'h00);
    `CHK(lat > 9 && lat <= 25, 1'b1)
    `CHK(readData, 8'h3D)
    {waitEnable, waitLen} = 5'h00;
  endtask
  // With the on-chip store enabled, only its window stays off the bus.
  task automatic testOnchip();
    {onchipSramEnable, onchipSramLoad} = 2'h3;
    @(negedge sys_clk);
    onchipSramLoad = 1'b0;
    `CHK(onchip_sram_enable_bit, 1'b1)
    xfer(KIND_DATA_READ, 16'h03FF, 8'h00);
    `CHK(sawOn, 1'b1)
    `CHK(lat, 0)
    xfer(KIND_DATA_READ, 16'h8001, 8'h00);
    `CHK(sawOn, 1'b0)
    `CHK(readData, 8'h3F)
  endtask
  task automatic finalReport();
    if (nFail == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reset spans two machine cycles, then the scenarios run in turn.
  initial begin
    repeat (RESET_HOLD_CLOCKS) @(negedge sys_clk);
    reset_n = 1'b1;
    testReset();
    testProgram();
    testData();
    testWait();
    testOnchip();
    finalReport();
  end
  // The scenarios need well under a thousand clocks; a hang ends the run.
  initial begin
    repeat (20000) @(posedge sys_clk);
    nFail++;
    finalReport();
  end
endmodule // external_memory_bus_port_bench

// file: sim/external_memory_bus_port_chk.sv
// Checker of the strobe and port relations of the external bus port.
`timescale 1ns/1ps
module external_memory_bus_port_chk (
  input wire logic sys_clk, reset_n, accessDone, onchip_sram_enable_bit,
  input wire logic addressLatchStrobe, lowPortOe, waitPinOe,
  input wire logic program_fetch_strobe_n, writeStrobe_n, readStrobe_n
);
  // ==========================================================================
  // Strobe timing
  // ==========================================================================
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Any memory strobe is low.
  wire anyLow = !(program_fetch_strobe_n && readStrobe_n && writeStrobe_n);
  // A fetch strobe stays low two clocks, then the access completes.
  sequence fetchTail;
    !program_fetch_strobe_n ##1 $rose(program_fetch_strobe_n) ##1 accessDone;
  endsequence
  a_fetch_pulse: assert property ($fell(program_fetch_strobe_n) |-> ##1 fetchTail)
    else $error("fetch strobe length or completion wrong");
  a_latch_one_clock: assert property ($rose(addressLatchStrobe) |=> !addressLatchStrobe)
    else $error("latch strobe longer than one clock");
  a_latch_then_strobe: assert property ($rose(addressLatchStrobe) |-> ##2 anyLow)
    else $error("memory strobe not two clocks after latch strobe");
  a_latch_addr_out: assert property (addressLatchStrobe |-> lowPortOe)
    else $error("low address not driven under latch strobe");
  a_release_first: assert property
    ($fell(readStrobe_n) || $fell(program_fetch_strobe_n) |-> !lowPortOe)
    else $error("low port still driven at read strobe");
  a_write_data_out: assert property (!writeStrobe_n |-> lowPortOe)
    else $error("write data not driven under write strobe");
  a_read_done: assert property ($rose(readStrobe_n) |=> accessDone)
    else $error("read completion not after strobe release");
  a_write_done: assert property ($rose(writeStrobe_n) |=> accessDone && !lowPortOe)
    else $error("write completion or port release missing");
  a_wait_undriven: assert property (!waitPinOe)
    else $error("wait pin driven");
  a_sram_reset: assert property (disable iff (1'b0) !reset_n |=> !onchip_sram_enable_bit)
    else $error("on-chip store enabled after reset");
endmodule // external_memory_bus_port_chk
bind external_memory_bus_port external_memory_bus_port_chk u_external_memory_bus_port_chk (.*);

// file: sim/memory_partner.sv
// Behavioural address latch, program store and data store on the far side.
`timescale 1ns/1ps
module memory_partner (
  // Clock and device pins.
  input  wire logic       sys_clk,
  input  wire logic       addressLatchStrobe, program_fetch_strobe_n,
  input  wire logic       readStrobe_n, writeStrobe_n, lowPortOe,
  input  wire logic [7:0] lowPortOut, highAddress,
  // Machine cycles of wait asked per access.
  input  wire logic [3:0] waitLen,
  output logic      [7:0] lowPortIn,
  output logic            waitPinIn
);
  logic [7:0]  latchedLow;            // Low address held by the latch.
  logic [7:0]  lastBus = 8'h55;       // Port level one clock ago.
  logic [5:0]  waitLeft;              // Clocks of wait still to ask.
  logic [7:0]  ram [0:65535];         // Data store.
  wire  [15:0] addr = {highAddress, latchedLow};
  wire         anyLow = !(program_fetch_strobe_n && readStrobe_n && writeStrobe_n);
  // The latch follows the port while its strobe is high and holds after it.
  always_ff @(posedge sys_clk) begin
    if (addressLatchStrobe) latchedLow <= lowPortOut;
    if (!writeStrobe_n) ram[addr] <= lowPortOut;
    if (addressLatchStrobe) waitLeft <= {waitLen, 2'b00};
    else if (anyLow && waitLeft != 6'h00) waitLeft <= waitLeft - 6'h01;
    lastBus <= lowPortIn;
  end
  // Memory drives only under its strobe; a released port shows a drifting level,
  // so a late sample by the device cannot pass by luck.
  always_comb begin
    if (!program_fetch_strobe_n) lowPortIn = addr[7:0] ^ addr[15:8] ^ 8'hA5;
    else if (!readStrobe_n) lowPortIn = ram[addr];
    else if (lowPortOe) lowPortIn = lowPortOut;
    else lowPortIn = ~lastBus;
  end
  assign waitPinIn = anyLow && waitLeft != 6'h00;
endmodule // memory_partner
